/* hw/mjio_regs.vh */
`ifndef MJIO_REGS_VH
`define MJIO_REGS_VH
// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define MJIO_OFS_CTRL 8'h00
`define MJIO_OFS_AUX_FUNC 8'h04
`define MJIO_OFS_SENSOR_FUNC 8'h08
`define MJIO_OFS_STAT_SEL 8'h0c
`define MJIO_OFS_STATE 8'h10
`define MJIO_OFS_EVENT 8'h14
// ----------------------------------------
// field codes and positions
// ----------------------------------------
`define MJIO_AUX_NONE 2'h0
`define MJIO_AUX_SENSOR 2'h1
`define MJIO_AUX_SYNC 2'h2
`define MJIO_STAT1_LSB 8
`define MJIO_EV_MANUAL 0
`define MJIO_EV_SYNC 1
// ----------------------------------------
// reset values
// ----------------------------------------
`define MJIO_RST_AUX_FUNC 4'h0
`define MJIO_RST_SENSOR_FUNC 4'h0
`define MJIO_RST_STAT_SEL0 5'h00
`define MJIO_RST_STAT_SEL1 5'h08
`define MJIO_PIN_IDLE 10'h3ff
// ----------------------------------------
// bus answers
// ----------------------------------------
`define MJIO_RESP_OKAY 2'h0
`define MJIO_RESP_DECERR 2'h3
// ----------------------------------------
// pin vector bit positions
// ----------------------------------------
`define MJIO_PIN_MAN 0
`define MJIO_PIN_HALT 1
`define MJIO_PIN_CW 2
`define MJIO_PIN_CCW 3
`define MJIO_PIN_SEL_A 4
`define MJIO_PIN_SEL_B 5
`define MJIO_PIN_SEL_C 6
`define MJIO_PIN_SEL_D 7
`define MJIO_PIN_SS0 8
`define MJIO_PIN_SS1 9
`endif

/* hw/mjio_sync.v */
`timescale 1ns/1ns
// ----------------------------------------
// three-stage pin synchroniser
// ----------------------------------------
module mjio_sync #(
   parameter WIDTH = 10,
   parameter [WIDTH-1:0] INIT_VAL = {WIDTH{1'b1}}
) (
   input wire ref_clk,
   input wire reset,
   input wire [WIDTH-1:0] pin_in,
   output wire [WIDTH-1:0] level_out
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg s1_reg;
         reg s2_reg;
         reg s3_reg;
         reg out_reg;
         // stage one is read only by stage two; output moves once two and three agree
         always @(posedge ref_clk) begin
            if (reset) begin
               s1_reg <= INIT_VAL[i];
               s2_reg <= INIT_VAL[i];
               s3_reg <= INIT_VAL[i];
               out_reg <= INIT_VAL[i];
            end else begin
               s1_reg <= pin_in[i];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg == s3_reg) begin
                  out_reg <= s3_reg;
               end
            end
         end
         assign level_out[i] = out_reg;
      end
   endgenerate
endmodule // mjio_sync

/* hw/mjio_status_mux.v */
`timescale 1ns/1ns
// ----------------------------------------
// status output selector, registered
// ----------------------------------------
module mjio_status_mux (
   input wire ref_clk,
   input wire reset,
   input wire [31:0] axis_status_in,
   input wire [4:0] sel_in,
   output reg status_out
);
   // select is {axis, signal}, so it indexes the flat status vector directly
   always @(posedge ref_clk) begin
      if (reset) begin
         status_out <= 1'b0;
      end else begin
         status_out <= axis_status_in[sel_in];
      end
   end
endmodule // mjio_status_mux

/* hw/mjio_top.v */
// Summary of operation
// RL1: a low manual-select level puts the port into manual jog mode.
// RL2: a high manual-select level returns the port to host-bus control.
// RL3: the manual permit output goes high only once the host has set the permit command.
// RL4: each auxiliary input can be assigned to a sensor or a synchronous-start function.
// RL5: after reset both auxiliary inputs have no function.
// RL6: auxiliary functions are off in manual mode and come back unchanged in bus mode.
// RL7: in manual mode the four select inputs together pick the one axis that jogs.
// RL8: the counter-clockwise jog input drives the selected axis only in manual mode.
// RL9: in manual mode the speed inputs are sensor inputs of the selected axis unless it has the up/down/constant setting, else ignored.
// RL10: in up/down/constant setting the speed inputs command accelerate, decelerate or hold.
// RL11: each status output can show any status signal of any axis.
// RL12: after reset status output 0 shows axis 0 compare status and output 1 that of axis 1.
// RL13: inputs have no filter time constant and no polarity option.
// RL14: the halt input stops pulse output on all axes at once in either mode.
// RL15: every port input passes a synchroniser before it is used.
`timescale 1ns/1ns
`include "mjio_regs.vh"
module mjio_top (
   input wire ref_clk,
   input wire reset,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire manual_select_in,
   input wire all_axis_halt_n,
   input wire cw_jog_command_n,
   input wire ccw_jog_command_n,
   input wire aux_input_0,
   input wire aux_input_1,
   input wire axis_sel_c_in,
   input wire axis_sel_d_in,
   input wire speed_command_0_n,
   input wire speed_command_1_n,
   input wire [31:0] axis_status_in,
   output wire manual_mode_out,
   output wire manual_permit_out,
   output wire halt_all_out,
   output wire [3:0] jog_axis_out,
   output wire jog_cw_out,
   output wire jog_ccw_out,
   output wire jog_accel_out,
   output wire jog_decel_out,
   output wire jog_const_out,
   output wire [1:0] axis_sensor_out,
   output wire [1:0] aux_sensor_out,
   output wire sync_start_out,
   output wire status_out_0,
   output wire status_out_1
);
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   wire [9:0] pin_raw, pin_lvl;
   assign pin_raw = {speed_command_1_n, speed_command_0_n, axis_sel_d_in, axis_sel_c_in,
      aux_input_1, aux_input_0, ccw_jog_command_n, cw_jog_command_n, all_axis_halt_n,
      manual_select_in};

   // all pins idle high, so reset leaves the port in bus mode with nothing asserted
   mjio_sync #(.WIDTH(10), .INIT_VAL(`MJIO_PIN_IDLE)) u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .pin_in(pin_raw),
      .level_out(pin_lvl)
   ); // RL15

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   reg permit_cmd_reg;
   reg [3:0] aux_func_reg, sensor_func_reg;
   reg [4:0] stat_sel0_reg, stat_sel1_reg;
   reg [1:0] event_reg;

   // ----------------------------------------
   // axi4-lite write channel
   // ----------------------------------------
   reg aw_rdy_reg, w_rdy_reg, aw_have_reg, w_have_reg, bvalid_reg;
   reg [7:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg [1:0] bresp_reg;
   wire aw_fire, w_fire, wr_commit, aw_have_next, w_have_next, bvalid_next, wr_hit;

   assign aw_fire = s_axi_awvalid & aw_rdy_reg;
   assign w_fire = s_axi_wvalid & w_rdy_reg;
   // commit only from latched copies, so address and data may come in either order
   assign wr_commit = aw_have_reg & w_have_reg & ~bvalid_reg;
   assign aw_have_next = wr_commit ? 1'b0 : (aw_have_reg | aw_fire);
   assign w_have_next = wr_commit ? 1'b0 : (w_have_reg | w_fire);
   assign bvalid_next = wr_commit ? 1'b1 : (bvalid_reg & ~s_axi_bready);

   // address decode for the committed write: aligned words from ctrl up to event
   assign wr_hit = (aw_addr_reg[1:0] == 2'h0) && (aw_addr_reg <= `MJIO_OFS_EVENT);

   // handshake state; ready drops while a write waits for its response
   always @(posedge ref_clk) begin
      if (reset) begin
         aw_rdy_reg <= 1'b0;
         w_rdy_reg <= 1'b0;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `MJIO_RESP_OKAY;
      end else begin
         aw_have_reg <= aw_have_next;
         w_have_reg <= w_have_next;
         aw_rdy_reg <= ~aw_have_next & ~bvalid_next;
         w_rdy_reg <= ~w_have_next & ~bvalid_next;
         bvalid_reg <= bvalid_next;
         if (aw_fire) begin
            aw_addr_reg <= s_axi_awaddr;
         end
         if (w_fire) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_commit) begin
            bresp_reg <= wr_hit ? `MJIO_RESP_OKAY : `MJIO_RESP_DECERR;
         end
      end
   end

   // ----------------------------------------
   // axi4-lite read channel
   // ----------------------------------------
   reg ar_rdy_reg, rvalid_reg, rd_hit;
   reg [31:0] rdata_reg, rd_word;
   reg [1:0] rresp_reg;
   wire ar_fire, rvalid_next;
   wire [31:0] state_word;

   assign ar_fire = s_axi_arvalid & ar_rdy_reg;
   assign rvalid_next = ar_fire ? 1'b1 : (rvalid_reg & ~s_axi_rready);

   // read mux; reserved bits read as zero
   always @* begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `MJIO_OFS_CTRL: rd_word = {31'h0000_0000, permit_cmd_reg};
         `MJIO_OFS_AUX_FUNC: rd_word = {28'h000_0000, aux_func_reg};
         `MJIO_OFS_SENSOR_FUNC: rd_word = {28'h000_0000, sensor_func_reg};
         `MJIO_OFS_STAT_SEL: rd_word = {19'h0_0000, stat_sel1_reg, 3'h0, stat_sel0_reg};
         `MJIO_OFS_STATE: rd_word = state_word;
         `MJIO_OFS_EVENT: rd_word = {30'h0000_0000, event_reg};
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         ar_rdy_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `MJIO_RESP_OKAY;
      end else begin
         rvalid_reg <= rvalid_next;
         ar_rdy_reg <= ~rvalid_next;
         if (ar_fire) begin
            rdata_reg <= rd_word;
            rresp_reg <= rd_hit ? `MJIO_RESP_OKAY : `MJIO_RESP_DECERR;
         end
      end
   end

   assign s_axi_awready = aw_rdy_reg;
   assign s_axi_wready = w_rdy_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = ar_rdy_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // ----------------------------------------
   // mode and pin decode
   // ----------------------------------------
   wire manual_next, halt_next, axis_is_udc, ss0_act, ss1_act;
   wire [3:0] sel_act, axis_next;
   wire [1:0] aux_act;

   // levels are used as they come out of the synchroniser, no filter and no inversion option
   assign manual_next = ~pin_lvl[`MJIO_PIN_MAN]; // RL1 RL2 RL13
   assign halt_next = ~pin_lvl[`MJIO_PIN_HALT]; // RL14
   assign sel_act = ~pin_lvl[`MJIO_PIN_SEL_D:`MJIO_PIN_SEL_A];
   assign ss0_act = ~pin_lvl[`MJIO_PIN_SS0];
   assign ss1_act = ~pin_lvl[`MJIO_PIN_SS1];
   assign aux_act = ~pin_lvl[`MJIO_PIN_SEL_B:`MJIO_PIN_SEL_A];

   // lowest active select wins, so at most one axis ever jogs
   assign axis_next = ~manual_next ? 4'h0 : sel_act[0] ? 4'h1 : sel_act[1] ? 4'h2 :
      sel_act[2] ? 4'h4 : sel_act[3] ? 4'h8 : 4'h0; // RL7

   assign axis_is_udc = |(sensor_func_reg & axis_next);

   // ----------------------------------------
   // manual jog outputs
   // ----------------------------------------
   reg manual_reg, halt_reg, jog_cw_reg, jog_ccw_reg;
   reg jog_accel_reg, jog_decel_reg, jog_const_reg;
   reg [3:0] jog_axis_reg;
   reg [1:0] axis_sensor_reg;
   wire jog_ok;

   // halt overrides jogging at once; no jog without a selected axis
   assign jog_ok = manual_next & (|axis_next) & ~halt_next; // RL14

   always @(posedge ref_clk) begin
      if (reset) begin
         manual_reg <= 1'b0;
         halt_reg <= 1'b0;
         jog_axis_reg <= 4'h0;
         jog_cw_reg <= 1'b0;
         jog_ccw_reg <= 1'b0;
         jog_accel_reg <= 1'b0;
         jog_decel_reg <= 1'b0;
         jog_const_reg <= 1'b0;
         axis_sensor_reg <= 2'h0;
      end else begin
         manual_reg <= manual_next; // RL1 RL2
         halt_reg <= halt_next; // RL14
         jog_axis_reg <= halt_next ? 4'h0 : axis_next; // RL7 RL14
         jog_cw_reg <= jog_ok & ~pin_lvl[`MJIO_PIN_CW];
         jog_ccw_reg <= jog_ok & ~pin_lvl[`MJIO_PIN_CCW]; // RL8
         // speed inputs mean nothing in bus mode
         jog_accel_reg <= jog_ok & axis_is_udc & ss0_act & ~ss1_act; // RL10
         jog_decel_reg <= jog_ok & axis_is_udc & ss1_act & ~ss0_act; // RL10
         jog_const_reg <= jog_ok & axis_is_udc & ~(ss0_act ^ ss1_act); // RL10
         axis_sensor_reg <= (manual_next & ~axis_is_udc & (|axis_next)) ?
            {ss1_act, ss0_act} : 2'h0; // RL9
      end
   end

   // ----------------------------------------
   // auxiliary input functions
   // ----------------------------------------
   reg [1:0] aux_sensor_reg, aux_prev_reg;
   reg sync_start_reg;
   wire [1:0] aux_is_sensor, aux_is_sync, aux_edge;
   wire sync_event;

   // functions stay stored through manual mode and act again on return
   assign aux_is_sensor = {aux_func_reg[3:2] == `MJIO_AUX_SENSOR,
      aux_func_reg[1:0] == `MJIO_AUX_SENSOR}; // RL4
   assign aux_is_sync = {aux_func_reg[3:2] == `MJIO_AUX_SYNC,
      aux_func_reg[1:0] == `MJIO_AUX_SYNC}; // RL4
   assign aux_edge = aux_act & ~aux_prev_reg;
   assign sync_event = ~manual_next & (|(aux_edge & aux_is_sync)); // RL6

   always @(posedge ref_clk) begin
      if (reset) begin
         aux_sensor_reg <= 2'h0;
         aux_prev_reg <= 2'h0;
         sync_start_reg <= 1'b0;
      end else begin
         // the previous level is tracked always, so leaving manual mode fires no stale edge
         aux_prev_reg <= aux_act;
         aux_sensor_reg <= manual_next ? 2'h0 : (aux_act & aux_is_sensor); // RL6
         sync_start_reg <= sync_event;
      end
   end

   // ----------------------------------------
   // register writes and sticky events
   // ----------------------------------------
   wire wr_en;
   wire [1:0] ev_set, ev_clr;
   assign wr_en = wr_commit & w_strb_reg[0];
   assign ev_set = {sync_event, manual_next & ~manual_reg};
   assign ev_clr = (wr_en && aw_addr_reg == `MJIO_OFS_EVENT) ? w_data_reg[1:0] : 2'h0;

   always @(posedge ref_clk) begin
      if (reset) begin
         permit_cmd_reg <= 1'b0; // RL3
         aux_func_reg <= `MJIO_RST_AUX_FUNC; // RL5
         sensor_func_reg <= `MJIO_RST_SENSOR_FUNC;
         stat_sel0_reg <= `MJIO_RST_STAT_SEL0; // RL12
         stat_sel1_reg <= `MJIO_RST_STAT_SEL1; // RL12
         event_reg <= 2'h0;
      end else begin
         // a set in the same cycle as the clear wins
         event_reg <= (event_reg & ~ev_clr) | ev_set;
         if (wr_en && aw_addr_reg == `MJIO_OFS_CTRL) begin
            permit_cmd_reg <= w_data_reg[0]; // RL3
         end
         if (wr_en && aw_addr_reg == `MJIO_OFS_AUX_FUNC) begin
            aux_func_reg <= w_data_reg[3:0]; // RL4
         end
         if (wr_en && aw_addr_reg == `MJIO_OFS_SENSOR_FUNC) begin
            sensor_func_reg <= w_data_reg[3:0]; // RL10
         end
         if (wr_en && aw_addr_reg == `MJIO_OFS_STAT_SEL) begin
            stat_sel0_reg <= w_data_reg[4:0]; // RL11
         end
         if (wr_commit && w_strb_reg[1] && aw_addr_reg == `MJIO_OFS_STAT_SEL) begin
            stat_sel1_reg <= w_data_reg[`MJIO_STAT1_LSB+4:`MJIO_STAT1_LSB]; // RL11
         end
      end
   end

   // ----------------------------------------
   // status outputs and permit
   // ----------------------------------------
   reg permit_out_reg;
   always @(posedge ref_clk) begin
      if (reset) begin
         permit_out_reg <= 1'b0;
      end else begin
         permit_out_reg <= permit_cmd_reg; // RL3
      end
   end

   mjio_status_mux u_stat0 (
      .ref_clk(ref_clk),
      .reset(reset),
      .axis_status_in(axis_status_in),
      .sel_in(stat_sel0_reg),
      .status_out(status_out_0)
   ); // RL11

   mjio_status_mux u_stat1 (
      .ref_clk(ref_clk),
      .reset(reset),
      .axis_status_in(axis_status_in),
      .sel_in(stat_sel1_reg),
      .status_out(status_out_1)
   ); // RL11

   // live state for software, read-only
   assign state_word = {18'h0_0000, aux_act, ss1_act, ss0_act, jog_ccw_reg, jog_cw_reg,
      jog_axis_reg, 1'b0, halt_reg, permit_out_reg, manual_reg};

   assign manual_mode_out = manual_reg;
   assign manual_permit_out = permit_out_reg;
   assign halt_all_out = halt_reg;
   assign jog_axis_out = jog_axis_reg;
   assign jog_cw_out = jog_cw_reg;
   assign jog_ccw_out = jog_ccw_reg;
   assign jog_accel_out = jog_accel_reg;
   assign jog_decel_out = jog_decel_reg;
   assign jog_const_out = jog_const_reg;
   assign axis_sensor_out = axis_sensor_reg;
   assign aux_sensor_out = aux_sensor_reg;
   assign sync_start_out = sync_start_reg;
endmodule // mjio_top

/* test/mjio_panel.sv */
`timescale 1ns/1ns
// ----------------------------------------
// operator panel model
// ----------------------------------------
module mjio_panel (
   input wire [9:0] press,
   output wire [9:0] pin_level
);
   // pulled-up contacts: a press pulls the pin low; no bounce, the port has no filter
   assign pin_level = ~press;
endmodule // mjio_panel

/* test/mjio_chk.sv */
`timescale 1ns/1ns
// ----------------------------------------
// port checks of the jog port
// ----------------------------------------
module mjio_chk (
   input wire ref_clk,
   input wire reset,
   input wire manual_select_in,
   input wire all_axis_halt_n,
   input wire manual_mode_out,
   input wire halt_all_out,
   input wire [3:0] jog_axis_out,
   input wire jog_cw_out,
   input wire jog_ccw_out,
   input wire jog_accel_out,
   input wire jog_decel_out,
   input wire jog_const_out,
   input wire [1:0] axis_sensor_out,
   input wire [1:0] aux_sensor_out,
   input wire sync_start_out
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // mode follows the pin five edges late
   a_man_enter: assert property (!manual_select_in [*6] |-> manual_mode_out)
      else $error("manual mode not entered");
   a_man_leave: assert property (manual_select_in [*6] |-> !manual_mode_out)
      else $error("bus mode not resumed");
   // a fresh pin edge must not reach the mode at once
   a_sync_delay: assert property ($fell(manual_select_in) && !manual_mode_out |->
      !manual_mode_out [*4])
      else $error("pin used before synchroniser");
   a_halt_enter: assert property (!all_axis_halt_n [*6] |-> halt_all_out)
      else $error("halt not raised");
   a_halt_jog: assert property (halt_all_out |-> jog_axis_out == 4'h0
      && !jog_cw_out && !jog_ccw_out && !jog_accel_out && !jog_decel_out && !jog_const_out)
      else $error("jog output during halt");
   a_bus_jog: assert property (!manual_mode_out |-> jog_axis_out == 4'h0
      && !jog_cw_out && !jog_ccw_out && axis_sensor_out == 2'h0)
      else $error("jog input used in bus mode");
   a_man_aux: assert property (manual_mode_out |-> aux_sensor_out == 2'h0 && !sync_start_out)
      else $error("aux function active in manual mode");
   a_axis_onehot: assert property ($onehot0(jog_axis_out))
      else $error("more than one jog axis");
   a_speed_one: assert property ($onehot0({jog_accel_out, jog_decel_out, jog_const_out}))
      else $error("conflicting speed commands");
   a_sync_pulse: assert property (sync_start_out |=> !sync_start_out)
      else $error("sync start longer than one cycle");
   c_ccw: cover property (jog_ccw_out);
   c_halt: cover property (halt_all_out);
   c_accel: cover property (jog_accel_out);
   c_sync: cover property (sync_start_out);
endmodule // mjio_chk
bind mjio_top mjio_chk chk_u (.ref_clk, .reset, .manual_select_in, .all_axis_halt_n,
   .manual_mode_out, .halt_all_out, .jog_axis_out, .jog_cw_out, .jog_ccw_out, .jog_accel_out,
   .jog_decel_out, .jog_const_out, .axis_sensor_out, .aux_sensor_out, .sync_start_out);

/* test/manual_jog_mode_io_bench.sv */
`timescale 1ns/1ns
`include "mjio_regs.vh"
module manual_jog_mode_io_bench;
   reg ref_clk = 1'b0;
   reg reset = 1'b1;
   reg [7:0] s_axi_awaddr = 8'h00;
   reg [7:0] s_axi_araddr = 8'h00;
   reg [31:0] s_axi_wdata = 32'h0000_0000;
   reg [3:0] s_axi_wstrb = 4'hf;
   reg s_axi_awvalid = 1'b0;
   reg s_axi_wvalid = 1'b0;
   reg s_axi_bready = 1'b0;
   reg s_axi_arvalid = 1'b0;
   reg s_axi_rready = 1'b0;
   reg [31:0] axis_status_in = 32'h0000_0000;
   reg [9:0] press = 10'h000;
   reg [19:0] rows [0:6];
   wire [9:0] pin_level;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp, axis_sensor_out, aux_sensor_out;
   wire [31:0] s_axi_rdata;
   wire [3:0] jog_axis_out;
   wire manual_mode_out, manual_permit_out, halt_all_out, jog_cw_out, jog_ccw_out;
   wire jog_accel_out, jog_decel_out, jog_const_out, sync_start_out, status_out_0, status_out_1;
   wire [9:0] obs;
   integer err_total = 0;
   integer comparisons = 0;
   integer sync_cnt = 0;
   integer i;
   // ----------------------------------------
   // design and panel
   // ----------------------------------------
   mjio_panel panel_u (.press(press), .pin_level(pin_level));
   mjio_top dut_u (.ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .manual_select_in(pin_level[`MJIO_PIN_MAN]),
      .all_axis_halt_n(pin_level[`MJIO_PIN_HALT]), .cw_jog_command_n(pin_level[`MJIO_PIN_CW]),
      .ccw_jog_command_n(pin_level[`MJIO_PIN_CCW]), .aux_input_0(pin_level[`MJIO_PIN_SEL_A]),
      .aux_input_1(pin_level[`MJIO_PIN_SEL_B]), .axis_sel_c_in(pin_level[`MJIO_PIN_SEL_C]),
      .axis_sel_d_in(pin_level[`MJIO_PIN_SEL_D]), .speed_command_0_n(pin_level[`MJIO_PIN_SS0]),
      .speed_command_1_n(pin_level[`MJIO_PIN_SS1]), .axis_status_in, .manual_mode_out,
      .manual_permit_out, .halt_all_out, .jog_axis_out, .jog_cw_out, .jog_ccw_out, .jog_accel_out,
      .jog_decel_out, .jog_const_out, .axis_sensor_out, .aux_sensor_out, .sync_start_out,
      .status_out_0, .status_out_1);
   assign obs = {manual_mode_out, halt_all_out, jog_axis_out, jog_cw_out, jog_ccw_out,
      axis_sensor_out};
   // ----------------------------------------
   // clock, pulse counter, checking tasks
   // ----------------------------------------
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   // sync start is a single-cycle pulse, so count it where it happens
   always @(posedge ref_clk) begin
      if (sync_start_out === 1'b1) sync_cnt <= sync_cnt + 1;
   end
   task check(input [31:0] seen, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("[ERR] %0t value %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // fixed wait: pin to output is five edges
   task settle;
      begin
         repeat (8) @(posedge ref_clk);
      end
   endtask
   // each wait ends on the answer; only the watchdog ends a hang
   task axi_wr(input [7:0] a, input [31:0] d, input [1:0] er);
      begin
         @(posedge ref_clk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         do begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         end while (s_axi_bvalid !== 1'b1);
         check({30'h0, s_axi_bresp}, {30'h0, er});
         s_axi_bready <= 1'b0;
      end
   endtask
   task axi_rd(input [7:0] a, input [31:0] ed, input [1:0] er);
      begin
         @(posedge ref_clk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         end while (s_axi_rvalid !== 1'b1);
         check(s_axi_rdata, ed);
         check({30'h0, s_axi_rresp}, {30'h0, er});
         s_axi_rready <= 1'b0;
      end
   endtask
   task print_verdict;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, err_total);
         if (err_total == 0 && comparisons > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   // a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total = err_total + 1;
      print_verdict;
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      // {pressed pins, expected manual halt axis cw ccw sensor}
      rows[0] = {10'h000, 10'h000};
      rows[1] = {10'h019, 10'h214};
      rows[2] = {10'h045, 10'h248};
      rows[3] = {10'h0a9, 10'h224};
      rows[4] = {10'h018, 10'h000};
      rows[5] = {10'h01b, 10'h300};
      rows[6] = {10'h181, 10'h281};
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      settle;
      axi_rd(`MJIO_OFS_CTRL, 32'h0000_0000, `MJIO_RESP_OKAY);
      axi_rd(`MJIO_OFS_AUX_FUNC, 32'h0000_0000, `MJIO_RESP_OKAY);
      axi_rd(`MJIO_OFS_SENSOR_FUNC, 32'h0000_0000, `MJIO_RESP_OKAY);
      axi_rd(`MJIO_OFS_STAT_SEL, {19'h0, `MJIO_RST_STAT_SEL1, 3'h0, `MJIO_RST_STAT_SEL0},
         `MJIO_RESP_OKAY);
      axi_rd(8'h18, 32'h0000_0000, `MJIO_RESP_DECERR);
      axi_wr(8'h18, 32'hffff_ffff, `MJIO_RESP_DECERR);
      for (i = 0; i < 7; i = i + 1) begin
         press <= rows[i][19:10];
         settle;
         check({22'h0, obs}, {22'h0, rows[i][9:0]});
      end
      // status outputs, default then reselected
      press <= 10'h000;
      axis_status_in <= 32'h0000_0001;
      settle;
      check({30'h0, status_out_1, status_out_0}, 32'h0000_0001);
      axis_status_in <= 32'h0000_0100;
      settle;
      check({30'h0, status_out_1, status_out_0}, 32'h0000_0002);
      axi_wr(`MJIO_OFS_STAT_SEL, 32'h0000_021d, `MJIO_RESP_OKAY);
      axis_status_in <= 32'h2000_0000;
      settle;
      check({30'h0, status_out_1, status_out_0}, 32'h0000_0001);
      axis_status_in <= 32'h0000_0004;
      settle;
      check({30'h0, status_out_1, status_out_0}, 32'h0000_0002);
      // permit output follows the host command only
      check({31'h0, manual_permit_out}, 32'h0000_0000);
      axi_wr(`MJIO_OFS_CTRL, 32'h0000_0001, `MJIO_RESP_OKAY);
      settle;
      check({31'h0, manual_permit_out}, 32'h0000_0001);
      axi_wr(`MJIO_OFS_CTRL, 32'h0000_0000, `MJIO_RESP_OKAY);
      settle;
      check({31'h0, manual_permit_out}, 32'h0000_0000);
      // aux inputs: unassigned, assigned, masked by manual mode, restored
      press <= 10'h030;
      settle;
      check({30'h0, aux_sensor_out}, 32'h0000_0000);
      check(sync_cnt, 32'h0000_0000);
      press <= 10'h000;
      axi_wr(`MJIO_OFS_AUX_FUNC, 32'h0000_0009, `MJIO_RESP_OKAY);
      press <= 10'h030;
      settle;
      check({30'h0, aux_sensor_out}, 32'h0000_0001);
      check(sync_cnt, 32'h0000_0001);
      press <= 10'h031;
      settle;
      check({30'h0, aux_sensor_out}, 32'h0000_0000);
      press <= 10'h030;
      settle;
      check({30'h0, aux_sensor_out}, 32'h0000_0001);
      axi_rd(`MJIO_OFS_AUX_FUNC, 32'h0000_0009, `MJIO_RESP_OKAY);
      // sticky events: manual entry and sync start seen, then cleared by writing ones
      axi_rd(`MJIO_OFS_EVENT, 32'h0000_0003, `MJIO_RESP_OKAY);
      axi_wr(`MJIO_OFS_EVENT, 32'h0000_0003, `MJIO_RESP_OKAY);
      axi_rd(`MJIO_OFS_EVENT, 32'h0000_0000, `MJIO_RESP_OKAY);
      // axis 0 speed inputs as up/down/constant command
      axi_wr(`MJIO_OFS_SENSOR_FUNC, 32'h0000_0001, `MJIO_RESP_OKAY);
      for (i = 0; i < 4; i = i + 1) begin
         press <= {i[1:0], 8'h11};
         settle;
         check({29'h0, jog_accel_out, jog_decel_out, jog_const_out},
            (i == 1) ? 32'h0000_0004 : (i == 2) ? 32'h0000_0002 : 32'h0000_0001);
         check({30'h0, axis_sensor_out}, 32'h0000_0000);
      end
      // live state: manual, axis 0, both speed inputs and select a pressed
      axi_rd(`MJIO_OFS_STATE, 32'h0000_1c11, `MJIO_RESP_OKAY);
      print_verdict;
   end
endmodule // manual_jog_mode_io_bench
